// File: rtl/ebm_pkg.sv
// Purpose: shared constants for the external bus mux and bank 0 decode
// Assumes: 25 MHz system clock, one clock domain
// Notes: address map offsets, pin positions and the filter and port reset values live here
`default_nettype none

package ebm_pkg;

  // ************************************************************
  // address map of bank 0
  // ************************************************************
  localparam logic [7:0] EBM_BANK0 = 8'h00;
  localparam logic [15:0] EBM_SFR_LAST = 16'h007F;
  localparam logic [15:0] EBM_RAM_FIRST = 16'h0080;
  localparam logic [15:0] EBM_RAM_LAST = 16'h047F;
  localparam logic [15:0] EBM_ROM_FIRST = 16'h8000;
  localparam logic [15:0] EBM_VEC_FIRST = 16'hFFD6;

  // ************************************************************
  // port indices and pin positions
  // ************************************************************
  localparam int EBM_NPORT = 5;
  localparam logic [2:0] EBM_PORT0 = 3'h0;
  localparam logic [2:0] EBM_PORT1 = 3'h1;
  localparam logic [2:0] EBM_PORT2 = 3'h2;
  localparam logic [2:0] EBM_PORT3 = 3'h3;
  localparam logic [2:0] EBM_PORT4 = 3'h4;
  localparam int EBM_P3_RW = 0;
  localparam int EBM_P3_UBE = 1;
  localparam int EBM_P3_ALE = 2;
  localparam int EBM_P3_GRANT = 3;
  localparam int EBM_P4_HOLD = 0;
  localparam int EBM_P4_RDY = 1;
  localparam int EBM_P4_PHI = 2;

  // ************************************************************
  // synchroniser layout: {byte_width_sel, proc_mode_select, p4, p3, p2, p1, p0}
  // ************************************************************
  localparam int EBM_SYNC_W = 38;
  localparam int EBM_SYNC_MODE = 36;
  localparam int EBM_SYNC_BYTE = 37;
  localparam int EBM_SYNC_P4 = 28;
  // hold and ready idle high (inactive) so nothing happens out of reset
  localparam logic [37:0] EBM_SYNC_RST = 38'h0030000000;

  // ************************************************************
  // timing and reset values
  // ************************************************************
  localparam logic [1:0] EBM_STRB_CYC = 2'h3;
  localparam logic [7:0] EBM_DIR_RST = 8'h00;
  localparam logic [7:0] EBM_DAT_RST = 8'h00;

  // bus sequencer states, one-hot
  typedef enum logic [4:0] {
    EBM_ST_IDLE = 5'b00001,
    EBM_ST_ADDR = 5'b00010,
    EBM_ST_STRB = 5'b00100,
    EBM_ST_DONE = 5'b01000,
    EBM_ST_HOLD = 5'b10000
  } ebm_state_t;

endpackage : ebm_pkg

`default_nettype wire

// File: rtl/ebm_bus_mux.sv
// Purpose: external multiplexed bus, port pin muxing and bank 0 decode
// Assumes: core logic on clk_sys issues accesses; pins are asynchronous
// Notes: pin output enables are active low (low while driving)
// Behaviour
// - BYTE low gives 16-bit bus, high 8-bit
// - single-chip pins follow per-port direction registers
// - reset sets every port pin to input
// - port 0 drives address 7..0 whenever the bus is owned
// - wide bus: port 1 data strobed, else address
// - narrow bus: port 1 carries only address
// - port 2 data strobed, else address 23..16
// - port 3 outputs rw, ube, ale, grant
// - port 4 bits 0,1 become hold, ready
// - port 4 bit 2 outputs clock by two
// - 24-bit space split into 64K banks
// - on-chip targets decoded only in bank 0
// - bank 0 8000..FFFF selects on-chip ROM unless in microprocessor mode
// - bank 0 FFD6..FFFF flags vector area
// - bank 0 80..47F selects on-chip RAM
// - bank 0 0..7F selects peripheral registers
// - direct page window from base plus offset
// - external transfers only while strobe low
`default_nettype none

module ebm_bus_mux (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // mode pins and mode control
  input wire logic proc_mode_select,
  input wire logic byte_width_sel,
  input wire logic mem_expand_en,
  input wire logic phi_out_en,
  // port register writes from core
  input wire logic dir_wr,
  input wire logic dat_wr,
  input wire logic [2:0] port_sel,
  input wire logic [7:0] port_wdata,
  // core access request
  input wire logic core_req,
  input wire logic core_write,
  input wire logic core_word,
  input wire logic core_dp,
  input wire logic [23:0] core_addr,
  input wire logic [7:0] core_dp_offset,
  input wire logic [15:0] direct_page_base,
  input wire logic [15:0] core_wdata,
  // core access answer
  output logic core_ack,
  output logic core_done_q,
  output logic [15:0] core_rdata_q,
  output logic sel_sfr_q,
  output logic sel_ram_q,
  output logic sel_rom_q,
  output logic sel_vector_q,
  output logic sel_none_q,
  // filtered pin levels for port reads
  output logic [7:0] port0_level_q,
  output logic [7:0] port1_level_q,
  output logic [7:0] port2_level_q,
  output logic [3:0] port3_level_q,
  output logic [7:0] port4_level_q,
  // enable strobe pin
  output logic enable_strobe_n,
  // port 0 pins
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe_n,
  // port 1 pins
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe_n,
  // port 2 pins
  input wire logic [7:0] p2_in,
  output logic [7:0] p2_out,
  output logic [7:0] p2_oe_n,
  // port 3 pins
  input wire logic [3:0] p3_in,
  output logic [3:0] p3_out,
  output logic [3:0] p3_oe_n,
  // port 4 pins
  input wire logic [7:0] p4_in,
  output logic [7:0] p4_out,
  output logic [7:0] p4_oe_n
);
  import ebm_pkg::*;

  // ************************************************************
  // decode functions
  // ************************************************************
  // region flags: {none, vector, rom, ram, sfr}; rom only when on-chip rom is used
  function automatic logic [4:0] ebm_decode(input logic [23:0] a, input logic rom_on);
    logic b0;
    logic sfr;
    logic ram;
    logic rom;
    b0 = (a[23:16] == EBM_BANK0);
    sfr = b0 && (a[15:0] <= EBM_SFR_LAST);
    ram = b0 && (a[15:0] >= EBM_RAM_FIRST) && (a[15:0] <= EBM_RAM_LAST);
    rom = rom_on && b0 && (a[15:0] >= EBM_ROM_FIRST);
    ebm_decode = {!(sfr || ram || rom), rom && (a[15:0] >= EBM_VEC_FIRST), rom, ram, sfr};
  endfunction : ebm_decode

  // direct page wraps inside bank 0
  function automatic logic [23:0] ebm_dp_addr(input logic [15:0] base, input logic [7:0] off);
    logic [15:0] sum;
    sum = base + {8'h00, off};
    ebm_dp_addr = {EBM_BANK0, sum};
  endfunction : ebm_dp_addr

  // ************************************************************
  // pin synchroniser and filter
  // ************************************************************
  logic [EBM_SYNC_W-1:0] sync1_q;
  logic [EBM_SYNC_W-1:0] sync2_q;
  logic [EBM_SYNC_W-1:0] sync3_q;
  logic [EBM_SYNC_W-1:0] filt_q;
  logic [EBM_SYNC_W-1:0] filt_d;
  wire [EBM_SYNC_W-1:0] raw_pins = {byte_width_sel, proc_mode_select, p4_in, p3_in, p2_in,
                                    p1_in, p0_in};

  // a bit changes only once stages two and three agree, which rejects single glitches
  assign filt_d = (~(sync2_q ^ sync3_q) & sync2_q) | ((sync2_q ^ sync3_q) & filt_q);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= EBM_SYNC_RST;
      sync2_q <= EBM_SYNC_RST;
      sync3_q <= EBM_SYNC_RST;
      filt_q <= EBM_SYNC_RST;
    end else begin
      sync1_q <= raw_pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= filt_d;
    end
  end

  // ************************************************************
  // mode selection
  // ************************************************************
  wire mode_micro = filt_q[EBM_SYNC_MODE];
  wire mode_exp = mode_micro || mem_expand_en;
  wire bus_wide = !filt_q[EBM_SYNC_BYTE];
  wire [7:0] lvl_p4 = filt_q[EBM_SYNC_P4 +: 8];
  wire hold_req = mode_exp && !lvl_p4[EBM_P4_HOLD];
  wire rdy_ok = lvl_p4[EBM_P4_RDY];
  // the pin levels exposed to the core are the filtered copies
  assign port0_level_q = filt_q[7:0];
  assign port1_level_q = filt_q[15:8];
  assign port2_level_q = filt_q[23:16];
  assign port3_level_q = filt_q[27:24];
  assign port4_level_q = lvl_p4;

  // ************************************************************
  // port direction and data registers
  // ************************************************************
  logic [7:0] dir_q [EBM_NPORT];
  logic [7:0] dat_q [EBM_NPORT];

  // direction zero means input; every port starts as input
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < EBM_NPORT; i++) begin
        dir_q[i] <= EBM_DIR_RST;
        dat_q[i] <= EBM_DAT_RST;
      end
    end else begin
      if (dir_wr && (port_sel <= EBM_PORT4)) begin
        dir_q[port_sel] <= port_wdata;
      end
      if (dat_wr && (port_sel <= EBM_PORT4)) begin
        dat_q[port_sel] <= port_wdata;
      end
    end
  end

  // ************************************************************
  // bus sequencer
  // ************************************************************
  ebm_state_t state_q;
  ebm_state_t state_d;
  logic [23:0] addr_q;
  logic [15:0] wdata_q;
  logic write_q;
  logic word_q;
  logic hi_q;
  logic [1:0] cnt_q;
  logic phi_q;
  logic [4:0] sel_q;

  wire [23:0] take_addr = core_dp ? ebm_dp_addr(direct_page_base, core_dp_offset) : core_addr;
  wire [4:0] take_sel = ebm_decode(take_addr, !mode_micro);
  wire take = core_req && core_ack;
  wire take_ext = take && take_sel[4] && mode_exp;
  wire strb_end = (cnt_q == EBM_STRB_CYC) && rdy_ok;
  // narrow bus word access runs a second byte cycle at the next address
  wire need_hi = word_q && !bus_wide && !hi_q;
  wire st_idle = (state_q == EBM_ST_IDLE);
  wire st_addr = (state_q == EBM_ST_ADDR);
  wire st_strb = (state_q == EBM_ST_STRB);
  wire st_hold = (state_q == EBM_ST_HOLD);

  // hold is only granted between transfers, never inside one
  assign core_ack = st_idle && !hold_req;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      EBM_ST_IDLE: begin
        if (hold_req) begin
          state_d = EBM_ST_HOLD;
        end else if (take_ext) begin
          state_d = EBM_ST_ADDR;
        end
      end
      EBM_ST_ADDR: begin
        state_d = EBM_ST_STRB;
      end
      EBM_ST_STRB: begin
        if (strb_end) begin
          state_d = EBM_ST_DONE;
        end
      end
      EBM_ST_DONE: begin
        state_d = need_hi ? EBM_ST_ADDR : EBM_ST_IDLE;
      end
      EBM_ST_HOLD: begin
        if (!hold_req) begin
          state_d = EBM_ST_IDLE;
        end
      end
      default: begin
        state_d = EBM_ST_IDLE;
      end
    endcase
  end

  // read data lands per byte lane; odd bytes on a wide bus come on port 1
  // the filter's next value is the first copy holding strobe data, so it is taken at done
  wire [7:0] lane_lo = filt_d[23:16];
  wire [7:0] lane_hi = filt_d[15:8];
  wire odd_wide = bus_wide && !word_q && addr_q[0];
  wire [15:0] rd_capt = hi_q ? {lane_lo, core_rdata_q[7:0]} :
                        (bus_wide && word_q) ? {lane_hi, lane_lo} :
                        odd_wide ? {8'h00, lane_hi} : {8'h00, lane_lo};

  // state and access context
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= EBM_ST_IDLE;
      addr_q <= 24'h000000;
      wdata_q <= 16'h0000;
      write_q <= 1'b0;
      word_q <= 1'b0;
      hi_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= (st_strb && !strb_end) ? ((cnt_q == EBM_STRB_CYC) ? cnt_q : cnt_q + 2'h1) :
               (st_addr ? 2'h1 : 2'h0);
      if (take) begin
        addr_q <= take_addr;
        wdata_q <= core_wdata;
        write_q <= core_write;
        word_q <= core_word;
        hi_q <= 1'b0;
      end else if ((state_q == EBM_ST_DONE) && need_hi) begin
        addr_q <= addr_q + 24'h000001;
        hi_q <= 1'b1;
      end
    end
  end

  // answers to the core: select pulses for on-chip targets, done for every access
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= 5'h00;
      core_done_q <= 1'b0;
      core_rdata_q <= 16'h0000;
    end else begin
      sel_q <= (take && !take_ext) ? take_sel : 5'h00;
      core_done_q <= (take && !take_ext) || ((state_q == EBM_ST_DONE) && !need_hi);
      if ((state_q == EBM_ST_DONE) && !write_q) begin
        core_rdata_q <= rd_capt;
      end
    end
  end
  assign sel_sfr_q = sel_q[0];
  assign sel_ram_q = sel_q[1];
  assign sel_rom_q = sel_q[2];
  assign sel_vector_q = sel_q[3];
  assign sel_none_q = sel_q[4];

  // free-running divide by two of the system clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phi_q <= 1'b0;
    end else begin
      phi_q <= !phi_q;
    end
  end

  // ************************************************************
  // pin multiplexing
  // ************************************************************
  wire bus_on = mode_exp && !st_hold;
  wire strobe_low = st_strb;
  wire drive_data = strobe_low && write_q;
  wire [7:0] wr_lo = hi_q ? wdata_q[15:8] : wdata_q[7:0];
  wire [7:0] wr_hi = word_q ? wdata_q[15:8] : wdata_q[7:0];
  wire ube_n = !(bus_wide && (word_q || addr_q[0]));
  wire in_cycle = st_addr || st_strb || (state_q == EBM_ST_DONE);
  wire phi_sel = mode_micro || phi_out_en;

  assign enable_strobe_n = !strobe_low;

  // port 0: address low byte whenever the bus is owned
  assign p0_out = bus_on ? addr_q[7:0] : dat_q[EBM_PORT0];
  assign p0_oe_n = mode_exp ? {8{st_hold}} : ~dir_q[EBM_PORT0];

  // port 1: upper data under strobe on a wide bus, address otherwise
  assign p1_out = !mode_exp ? dat_q[EBM_PORT1] :
                  (bus_wide && strobe_low) ? wr_hi : addr_q[15:8];
  assign p1_oe_n = !mode_exp ? ~dir_q[EBM_PORT1] :
                   {8{st_hold || (bus_wide && strobe_low && !write_q)}};

  // port 2: lower data under strobe, bank byte otherwise
  assign p2_out = !mode_exp ? dat_q[EBM_PORT2] : (strobe_low ? wr_lo : addr_q[23:16]);
  assign p2_oe_n = !mode_exp ? ~dir_q[EBM_PORT2] :
                   {8{st_hold || (strobe_low && !drive_data)}};

  // port 3: bus control; the grant stays driven while others are released
  assign p3_out = !mode_exp ? dat_q[EBM_PORT3][3:0] :
                  {!st_hold, st_addr, ube_n, !(in_cycle && write_q)};
  assign p3_oe_n = !mode_exp ? ~dir_q[EBM_PORT3][3:0] : {1'b0, {3{st_hold}}};

  // port 4: hold and ready become inputs, bit 2 may carry the divided clock
  assign p4_out = {dat_q[EBM_PORT4][7:3], phi_sel ? phi_q : dat_q[EBM_PORT4][2],
                   dat_q[EBM_PORT4][1:0]};
  assign p4_oe_n = {~dir_q[EBM_PORT4][7:3], phi_sel ? 1'b0 : ~dir_q[EBM_PORT4][2],
                    mode_exp ? 2'b11 : ~dir_q[EBM_PORT4][1:0]};

  // ************************************************************
  // assertions
  // ************************************************************
  sequence seq_addr_phase;
    p3_out[EBM_P3_ALE] && enable_strobe_n;
  endsequence
  sequence seq_strobe_phase;
    !enable_strobe_n [*3];
  endsequence

  a_ext_cycle_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
    take_ext |=> seq_addr_phase ##1 seq_strobe_phase)
    else $error("external cycle did not run address then strobe");

  a_p0_addr_out: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mode_exp && !st_hold) |-> (p0_oe_n == 8'h00) && (p0_out == addr_q[7:0]))
    else $error("port 0 not carrying address");

  a_p1_narrow_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mode_exp && !bus_wide && !st_hold) |-> (p1_oe_n == 8'h00) && (p1_out == addr_q[15:8]))
    else $error("port 1 not address on narrow bus");

  a_p1_wide_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mode_exp && bus_wide && !enable_strobe_n && !write_q) |-> (p1_oe_n == 8'hFF))
    else $error("port 1 driven during wide read strobe");

  a_p2_bank_out: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mode_exp && enable_strobe_n && !st_hold) |-> (p2_out == addr_q[23:16]) && !p2_oe_n[0])
    else $error("port 2 not carrying bank address");

  a_single_dir: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !mode_exp |-> (p0_oe_n == ~dir_q[EBM_PORT0]) && (p2_oe_n == ~dir_q[EBM_PORT2]))
    else $error("single-chip direction not followed");

  a_phi_toggle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mode_micro && $past(mode_micro)) |-> (p4_out[EBM_P4_PHI] != $past(p4_out[EBM_P4_PHI])))
    else $error("divided clock not toggling");

  a_hold_grant: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st_idle && hold_req) |=> !p3_out[EBM_P3_GRANT] && (p3_oe_n == 4'h7))
    else $error("hold not granted with bus released");

  a_ram_select: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (take && (take_addr[23:16] == 8'h00) && (take_addr[15:0] >= 16'h0080) &&
     (take_addr[15:0] <= 16'h047F)) |=> sel_ram_q && core_done_q)
    else $error("ram access not selected");

  a_vector_rom: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (take && !mode_micro && (take_addr[23:16] == EBM_BANK0) &&
     (take_addr[15:0] >= EBM_VEC_FIRST)) ##1 1'b1 |-> sel_rom_q && sel_vector_q)
    else $error("vector area not flagged");

  a_dp_window: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (take && core_dp) |=> (addr_q[23:16] == 8'h00) &&
      (addr_q[15:0] == $past(direct_page_base) + {8'h00, $past(core_dp_offset)}))
    else $error("direct page address wrong");

  a_reset_inputs: assert property (@(posedge clk_sys)
    $rose(reset_n) && !mode_exp |-> (p0_oe_n == 8'hFF) && (p1_oe_n == 8'hFF))
    else $error("ports not inputs after reset");

endmodule : ebm_bus_mux

`default_nettype wire

// File: verif/ebm_ext_mem.sv
// Purpose: external memory model on the multiplexed address/data bus
// Assumes: pins are resolved here from the block's out/oe_n and this model
// Notes: released lines show the inverse of their last level, so stale data cannot pass
`default_nettype none

module ebm_ext_mem (
  // clock, reset and test controls
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic hold_req_n,
  // block pins
  input wire logic enable_strobe_n,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe_n,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe_n,
  input wire logic [7:0] p2_out,
  input wire logic [7:0] p2_oe_n,
  input wire logic [3:0] p3_out,
  input wire logic [3:0] p3_oe_n,
  input wire logic [7:0] p4_out,
  input wire logic [7:0] p4_oe_n,
  // resolved pin levels
  output logic [7:0] p0_in,
  output logic [7:0] p1_in,
  output logic [7:0] p2_in,
  output logic [3:0] p3_in,
  output logic [7:0] p4_in,
  // observations
  output logic [23:0] addr_q,
  output logic [15:0] wdata_q,
  output logic [7:0] strobe_len,
  output logic [7:0] n_cyc,
  output logic [7:0] p1oe_acc,
  output logic ube_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] l0, l1, l2, l4, scnt;
  logic [3:0] l3;
  logic rd_phase, rdy;

  // memory contents are a fixed hash of the byte address
  function automatic logic [7:0] mb(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction : mb

  // read data only in the strobe phase of a read; wide when p1 is released
  assign rd_phase = !enable_strobe_n && p3_out[0];
  // slow mode holds ready low from idle through four strobe cycles; the block sees
  // ready only after its input filter, so a drop at strobe start would come too late
  assign rdy = !(slow && scnt < 8'h04);
  assign p0_in = (p0_out & ~p0_oe_n) | (~l0 & p0_oe_n);
  assign p1_in = (p1_out & ~p1_oe_n) |
                 ((rd_phase ? mb({addr_q[23:1], 1'b1}) : ~l1) & p1_oe_n);
  assign p2_in = (p2_out & ~p2_oe_n) | ((rd_phase ? (p1_oe_n == 8'hFF ?
                 mb({addr_q[23:1], 1'b0}) : mb(addr_q)) : ~l2) & p2_oe_n);
  assign p3_in = (p3_out & ~p3_oe_n) | (~l3 & p3_oe_n);
  assign p4_in = (p4_out & ~p4_oe_n) | ({~l4[7:2], rdy, hold_req_n} & p4_oe_n);

  // latch address on ALE, capture writes, measure strobe length
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {l0, l1, l2, l3, l4, scnt, strobe_len, n_cyc, p1oe_acc} <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      ube_q <= 1'b1;
    end else begin
      {l0, l1, l2, l3, l4} <= {p0_in, p1_in, p2_in, p3_in, p4_in};
      if (p3_out[2]) begin
        addr_q <= {p2_in, p1_in, p0_in};
        p1oe_acc <= '0;
      end
      if (!enable_strobe_n) begin
        scnt <= scnt + 8'h01;
        p1oe_acc <= p1oe_acc | p1_oe_n;
        ube_q <= p3_out[1];
        if (!p3_out[0]) wdata_q <= {p1_in, p2_in};
      end else begin
        if (scnt != 8'h00) begin
          strobe_len <= scnt;
          n_cyc <= n_cyc + 8'h01;
        end
        scnt <= '0;
      end
    end
  end
endmodule : ebm_ext_mem

`default_nettype wire

// File: verif/testbench.sv
// Purpose: self-checking bench for the bus mux and bank 0 decode
// Assumes: 25 MHz clk_sys, external memory model on the pins
// Notes: mode pins are given eight cycles to pass the input filter
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ebm_pkg::*;

  logic clk_sys = 0, reset_n = 0, proc_mode_select = 0, byte_width_sel = 0;
  logic mem_expand_en = 0, phi_out_en = 0, dir_wr = 0, dat_wr = 0, slow = 0, hold_n = 1;
  logic core_req = 0, core_write = 0, core_word = 0, core_dp = 0, core_ack, core_done_q;
  logic [2:0] port_sel = 0;
  logic [7:0] port_wdata = 0, dp_off = 0, strobe_len, n_cyc, p1oe_acc, c0;
  logic [23:0] core_addr = 0, addr_q;
  logic [15:0] dp_base = 0, core_wdata = 0, core_rdata_q, wdata_q, rd;
  logic sel_sfr_q, sel_ram_q, sel_rom_q, sel_vector_q, sel_none_q, ube_q, enable_strobe_n;
  logic [4:0] sel;
  logic [7:0] p0_in, p0_out, p0_oe_n, p1_in, p1_out, p1_oe_n, p2_in, p2_out, p2_oe_n;
  logic [7:0] p4_in, p4_out, p4_oe_n;
  logic [3:0] p3_in, p3_out, p3_oe_n;
  int n_fail = 0, compares = 0, cycles = 0;
  logic [23:0] da[9] = '{24'h000000, 24'h00007F, 24'h000080, 24'h00047F, 24'h000480,
                        24'h008000, 24'h00FFD5, 24'h00FFD6, 24'h010000};
  logic [4:0] ds[9] = '{5'h10, 5'h10, 5'h08, 5'h08, 5'h01, 5'h04, 5'h04, 5'h06, 5'h01};

  always #20 clk_sys = ~clk_sys;

  ebm_bus_mux ebm_bus_mux_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .proc_mode_select(proc_mode_select), .byte_width_sel(byte_width_sel),
    .mem_expand_en(mem_expand_en), .phi_out_en(phi_out_en), .dir_wr(dir_wr), .dat_wr(dat_wr),
    .port_sel(port_sel), .port_wdata(port_wdata), .core_req(core_req), .core_write(core_write),
    .core_word(core_word), .core_dp(core_dp), .core_addr(core_addr), .core_dp_offset(dp_off),
    .direct_page_base(dp_base), .core_wdata(core_wdata), .core_ack(core_ack),
    .core_done_q(core_done_q), .core_rdata_q(core_rdata_q), .sel_sfr_q(sel_sfr_q),
    .sel_ram_q(sel_ram_q), .sel_rom_q(sel_rom_q), .sel_vector_q(sel_vector_q),
    .sel_none_q(sel_none_q), .port0_level_q(), .port1_level_q(), .port2_level_q(),
    .port3_level_q(), .port4_level_q(), .enable_strobe_n(enable_strobe_n),
    .p0_in(p0_in), .p0_out(p0_out), .p0_oe_n(p0_oe_n), .p1_in(p1_in), .p1_out(p1_out),
    .p1_oe_n(p1_oe_n), .p2_in(p2_in), .p2_out(p2_out), .p2_oe_n(p2_oe_n), .p3_in(p3_in),
    .p3_out(p3_out), .p3_oe_n(p3_oe_n), .p4_in(p4_in), .p4_out(p4_out), .p4_oe_n(p4_oe_n));

  ebm_ext_mem ebm_ext_mem_i (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow),
    .hold_req_n(hold_n), .enable_strobe_n(enable_strobe_n), .p0_out(p0_out), .p0_oe_n(p0_oe_n),
    .p1_out(p1_out), .p1_oe_n(p1_oe_n), .p2_out(p2_out), .p2_oe_n(p2_oe_n), .p3_out(p3_out),
    .p3_oe_n(p3_oe_n), .p4_out(p4_out), .p4_oe_n(p4_oe_n), .p0_in(p0_in), .p1_in(p1_in),
    .p2_in(p2_in), .p3_in(p3_in), .p4_in(p4_in), .addr_q(addr_q), .wdata_q(wdata_q),
    .strobe_len(strobe_len), .n_cyc(n_cyc), .p1oe_acc(p1oe_acc), .ube_q(ube_q));

  function automatic logic [7:0] mb(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction : mb

  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // one core access; the request stands until the edge where ack is high
  task automatic acc(input logic [23:0] a, input logic w, input logic wd, input logic dp,
                     input logic [15:0] d);
    int n;
    @(posedge clk_sys);
    {core_req, core_addr, core_write, core_word, core_dp, core_wdata} <= {1'b1, a, w, wd, dp, d};
    n = 0;
    @(negedge clk_sys);
    while (core_ack !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    core_req <= 1'b0;
    @(negedge clk_sys);
    while (core_done_q !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n < 60, 1, "access finished");
    sel = {sel_sfr_q, sel_ram_q, sel_rom_q, sel_vector_q, sel_none_q};
    rd = core_rdata_q;
  endtask : acc

  task automatic wrport(input logic [2:0] p, input logic dir, input logic [7:0] v);
    @(posedge clk_sys);
    {port_sel, port_wdata, dir_wr, dat_wr} <= {p, v, dir, !dir};
    @(posedge clk_sys);
    {dir_wr, dat_wr} <= 2'b00;
    repeat (2) @(negedge clk_sys);
  endtask : wrport

  task automatic t_single();
    chk({p0_oe_n, p1_oe_n, p2_oe_n}, 24'hFFFFFF, "reset dir");
    chk({p3_oe_n, p4_oe_n, enable_strobe_n}, 13'h1FFF, "reset dir 3 4");
    wrport(EBM_PORT0, 1, 8'hA5);
    wrport(EBM_PORT0, 0, 8'h3C);
    wrport(EBM_PORT3, 1, 8'h05);
    chk({p0_oe_n, p0_out & 8'hA5, 4'h0, p3_oe_n}, 24'h5A240A, "port dir");
    wrport(EBM_PORT0, 1, 8'h00);
    wrport(EBM_PORT3, 1, 8'h00);
    for (int i = 0; i < 9; i++) begin
      acc(da[i], 0, 0, 0, 16'h0000);
      chk(sel, ds[i], "decode");
    end
    dp_base <= 16'h0040;
    dp_off <= 8'h50;
    acc(24'hFFFFFF, 0, 0, 1, 16'h0000);
    chk(sel, 5'h08, "direct page ram");
    dp_base <= 16'hFFF0;
    dp_off <= 8'h20;
    acc(24'hFFFFFF, 0, 0, 1, 16'h0000);
    chk(sel, 5'h10, "direct page wrap");
    phi_out_en <= 1'b1;
    repeat (2) @(negedge clk_sys);
    c0 = {7'h00, p4_out[EBM_P4_PHI]};
    @(negedge clk_sys);
    chk({p4_oe_n[EBM_P4_PHI], p4_out[EBM_P4_PHI]}, {1'b0, !c0[0]}, "phi");
    phi_out_en <= 1'b0;
  endtask : t_single

  task automatic t_wide();
    mem_expand_en <= 1'b1;
    repeat (8) @(negedge clk_sys);
    chk({p0_oe_n, p3_oe_n, p3_out[3:2]}, 14'h0002, "bus pins idle");
    acc(24'h123456, 0, 1, 0, 16'h0000);
    chk(rd, {mb(24'h123457), mb(24'h123456)}, "wide read");
    chk(addr_q, 24'h123456, "address");
    chk({p1oe_acc, strobe_len}, {8'hFF, 6'h0, EBM_STRB_CYC}, "strobe");
    acc(24'h300020, 1, 1, 0, 16'hBEEF);
    chk({wdata_q, 7'h0, ube_q}, 24'hBEEF00, "wide write");
    acc(24'h123457, 0, 0, 0, 16'h0000);
    chk({rd, 7'h0, ube_q}, {8'h00, mb(24'h123457), 8'h00}, "odd byte");
    slow <= 1'b1;
    acc(24'h0004A0, 0, 1, 0, 16'h0000);
    chk({rd, 7'h0, strobe_len > 8'h04}, {mb(24'h0004A1), mb(24'h0004A0), 8'h01},
        "ready");
    slow <= 1'b0;
    byte_width_sel <= 1'b1;
    repeat (8) @(negedge clk_sys);
    c0 = n_cyc;
    acc(24'h200010, 0, 1, 0, 16'h0000);
    chk(rd, {mb(24'h200011), mb(24'h200010)}, "narrow read");
    chk({p1oe_acc, n_cyc - c0}, 16'h0002, "narrow cycles");
    byte_width_sel <= 1'b0;
    hold_n <= 1'b0;
    repeat (8) @(negedge clk_sys);
    chk({p3_out[EBM_P3_GRANT], p0_oe_n, core_ack}, 10'h1FE, "hold grant");
    hold_n <= 1'b1;
    repeat (8) @(negedge clk_sys);
    chk(p3_out[EBM_P3_GRANT], 1, "hold release");
  endtask : t_wide

  task automatic t_micro();
    mem_expand_en <= 1'b0;
    proc_mode_select <= 1'b1;
    repeat (8) @(negedge clk_sys);
    c0 = {7'h00, p4_out[EBM_P4_PHI]};
    @(negedge clk_sys);
    chk({p4_oe_n[EBM_P4_PHI], p4_out[EBM_P4_PHI]}, {1'b0, !c0[0]}, "phi forced");
    c0 = n_cyc;
    acc(24'h008000, 0, 1, 0, 16'h0000);
    chk({sel[2], n_cyc - c0}, 9'h001, "rom off");
    chk(rd, {mb(24'h008001), mb(24'h008000)}, "rom external");
  endtask : t_micro

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (6) @(negedge clk_sys);
    t_single();
    t_wide();
    t_micro();
    stop_test();
  end
endmodule : testbench

`default_nettype wire
